// ### verilog/ics_sequencer.sv
// Module: control logic of a two-wire serial bus sequencer behind an APB slave
//
// Notes on behaviour
// - Enable bit 15 hands both lines to the module; clear returns them to port.
// - Idle-stop bit 13 halts the module in Idle mode, else continues.
// - Slave: release bit 12 (reset 1) low holds clock low, high releases.
// - Stretch on: release R/W; cleared at slave transmit start and receive end.
// - Stretch off: software can only set release; cleared at transmit start.
// - Stretch enable bit 6 permits software and receive stretching.
// - Strict bit 11 blocks reserved addresses for 7-bit own address response only.
// - Address width bit 10 picks 10-bit or 7-bit own address compare.
// - General call enable bit 7 raises interrupt on general call, else ignored.
// - Receive request bit 3 receives one byte; cleared after eighth bit.
// - Stop request bit 2 generates Stop; cleared when done.
// - Start request bit 0 generates Start; cleared when done.
// - Control bits 31-16 and bit 14 read zero.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ics_sequencer
  import ics_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        serial_clock_line_in,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe,
  output logic             pins_owned,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0]         control,     next_control;
  logic [9:0]          own_slave_address, next_own_slave_address;
  logic [ST_WIDTH-1:0] status,      next_status;
  logic [ST_WIDTH-1:0] irq_enable,  next_irq_enable;
  logic [7:0]          receive_shift_register, next_receive_shift_register;
  logic [7:0]          rx_data,     next_rx_data;
  logic [2:0]          bitcnt,      next_bitcnt;
  logic [15:0]         timer,       next_timer;
  ics_seq_t            seq,         next_seq;
  ics_pins_t           drive,       next_drive;
  logic                rx_phase,    next_rx_phase;
  logic [31:0]         next_prdata;
  // Slave-side tracking
  logic [3:0]          sl_cnt,      next_sl_cnt;
  logic [7:0]          sl_shift,    next_sl_shift;
  logic                sl_active,   next_sl_active;
  logic                sl_addr_ph,  next_sl_addr_ph;
  logic                sl_tx,       next_sl_tx;
  logic                scl_d,       next_scl_d;
  logic                sda_d,       next_sda_d;
  logic [1:0]          pin_sync;
  logic                scl_s, sda_s;

  // ----------------------------------------------------------------
  // Pin inputs pass two flip-flops before use
  // ----------------------------------------------------------------
  ics_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({serial_clock_line_in, serial_data_line_in}),
    .q       (pin_sync)
  );
  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];

  // Reserved address space: 0000xxx and 1111xxx
  function automatic logic is_reserved(input logic [6:0] a);
    return (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
  endfunction : is_reserved

  // ----------------------------------------------------------------
  // Derived conditions
  // ----------------------------------------------------------------
  logic apb_wr, apb_rd, running, scl_rise, scl_fall, start_seen, stop_seen;
  logic addr_match, gcall_hit, sl_byte_done;
  assign apb_wr     = psel && penable && pwrite;
  assign apb_rd     = psel && !penable && !pwrite;
  // Idle mode halts sequencing when idle-stop is set
  assign running    = control[BIT_ENABLE] && !(control[BIT_IDLE_STOP] && idle_mode);
  assign scl_rise   = scl_s && !scl_d;
  assign scl_fall   = !scl_s && scl_d;
  assign start_seen = scl_s && sda_d && !sda_s;
  assign stop_seen  = scl_s && !sda_d && sda_s;
  assign sl_byte_done = scl_fall && (sl_cnt == 4'd8);
  // 10-bit mode matches the 11110 prefix and the top two address bits
  assign addr_match = control[BIT_LONG_ADDR] ?
                      (sl_shift[7:3] == 5'b11110 && sl_shift[2:1] == own_slave_address[9:8]) :
                      (sl_shift[7:1] == own_slave_address[6:0] &&
                       !(control[BIT_STRICT] && is_reserved(sl_shift[7:1])));
  assign gcall_hit  = sl_shift == 8'h00;

  // ----------------------------------------------------------------
  // Slave-side bus observer: frames, address phase, byte counting
  // ----------------------------------------------------------------
  always_comb begin
    next_scl_d      = scl_s;
    next_sda_d      = sda_s;
    next_sl_cnt     = sl_cnt;
    next_sl_shift   = sl_shift;
    next_sl_active  = sl_active;
    next_sl_addr_ph = sl_addr_ph;
    next_sl_tx      = sl_tx;
    if (!running || stop_seen) begin
      next_sl_active  = 1'b0;
      next_sl_addr_ph = 1'b0;
      next_sl_cnt     = 4'd0;
    end else if (start_seen) begin
      next_sl_addr_ph = 1'b1;
      next_sl_cnt     = 4'd0;
    end else begin
      if (scl_rise && sl_cnt < 4'd8) begin
        next_sl_shift = {sl_shift[6:0], sda_s};
        next_sl_cnt   = sl_cnt + 4'd1;
      end
      if (sl_byte_done) begin
        next_sl_cnt = 4'd9;
        if (sl_addr_ph) begin
          next_sl_addr_ph = 1'b0;
          next_sl_active  = addr_match || (gcall_hit && control[BIT_GCALL]);
          next_sl_tx      = addr_match && sl_shift[0];
        end
      end else if (scl_fall && sl_cnt == 4'd9) begin
        next_sl_cnt = 4'd0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master sequence engine: start, repeated start, stop, receive, ack
  // ----------------------------------------------------------------
  logic       seq_done;
  logic [4:0] done_mask;
  always_comb begin
    next_seq      = seq;
    next_timer    = timer;
    next_drive    = drive;
    next_bitcnt   = bitcnt;
    next_rx_phase = rx_phase;
    next_receive_shift_register = receive_shift_register;
    seq_done      = 1'b0;
    done_mask     = 5'b00000;
    if (!running) begin
      next_seq   = SEQ_IDLE;
      next_drive = '0;
    end else if (timer != 16'h0000) begin
      next_timer = timer - 16'h0001;
    end else begin
      next_timer = 16'(HALF_CYC - 1);
      unique case (seq)
        SEQ_IDLE: begin
          if (control[BIT_START_REQ]) begin
            // No master transmit here, so strict mode has no address to block
            next_seq = SEQ_ST_A;
          end else if (control[BIT_RSTART_REQ]) begin
            next_seq = SEQ_RS_A;
            next_drive.sda_oe = 1'b0;
          end else if (control[BIT_STOP_REQ]) begin
            next_seq = SEQ_SP_A;
            next_drive.sda_oe = 1'b1;
          end else if (control[BIT_RX_REQ]) begin
            next_seq = SEQ_BIT_LO;
            next_bitcnt = 3'd7;
            next_rx_phase = 1'b1;
            next_drive.sda_oe = 1'b0;
          end else if (control[BIT_ACK_REQ]) begin
            next_seq = SEQ_BIT_LO;
            next_rx_phase = 1'b0;
            next_drive.sda_oe = !control[BIT_ACK_VALUE];
          end else begin
            next_timer = 16'h0000;
          end
        end
        SEQ_ST_A: begin
          next_drive.sda_oe = 1'b1;
          next_seq = SEQ_ST_B;
        end
        SEQ_ST_B: begin
          next_drive.scl_oe = 1'b1;
          next_seq = SEQ_IDLE;
          seq_done = 1'b1;
          done_mask[BIT_START_REQ] = 1'b1;
        end
        SEQ_RS_A: begin
          next_drive.scl_oe = 1'b0;
          next_seq = SEQ_RS_B;
        end
        SEQ_RS_B: begin
          next_drive.sda_oe = 1'b1;
          next_seq = SEQ_ST_B;
          done_mask[BIT_RSTART_REQ] = 1'b1;
        end
        SEQ_SP_A: begin
          next_drive.scl_oe = 1'b0;
          next_seq = SEQ_SP_B;
        end
        SEQ_SP_B: begin
          next_drive.sda_oe = 1'b0;
          next_seq = SEQ_SP_C;
        end
        SEQ_SP_C: begin
          next_seq = SEQ_IDLE;
          seq_done = 1'b1;
          done_mask[BIT_STOP_REQ] = 1'b1;
        end
        SEQ_BIT_LO: begin
          next_drive.scl_oe = 1'b0;
          next_seq = SEQ_BIT_HI;
        end
        SEQ_BIT_HI: begin
          next_drive.scl_oe = 1'b1;
          if (rx_phase) begin
            next_receive_shift_register = {receive_shift_register[6:0], sda_s};
            if (bitcnt == 3'd0) begin
              next_seq = SEQ_IDLE;
              seq_done = 1'b1;
              done_mask[BIT_RX_REQ] = 1'b1;
            end else begin
              next_bitcnt = bitcnt - 3'd1;
              next_seq = SEQ_BIT_LO;
            end
          end else begin
            next_drive.sda_oe = 1'b0;
            next_seq = SEQ_IDLE;
            seq_done = 1'b1;
            done_mask[BIT_ACK_REQ] = 1'b1;
          end
        end
        default: next_seq = SEQ_IDLE;
      endcase
    end
    // Slave stretch: hold clock low while release is clear
    if (running && seq == SEQ_IDLE && sl_active && !control[BIT_RELEASE])
      next_drive.scl_oe = 1'b1;
    else if (running && seq == SEQ_IDLE && sl_active)
      next_drive.scl_oe = 1'b0;
  end

  // ----------------------------------------------------------------
  // Register file: control with hardware clears, address, interrupts
  // ----------------------------------------------------------------
  logic rel_hw_clr, sl_tx_begin, sl_rx_end;
  assign sl_tx_begin = sl_byte_done && sl_addr_ph && addr_match && sl_shift[0];
  assign sl_rx_end   = sl_byte_done && !sl_addr_ph && sl_active && !sl_tx;
  assign rel_hw_clr  = sl_tx_begin || (control[BIT_STRETCH] && sl_rx_end);
  always_comb begin
    next_control           = control;
    next_own_slave_address = own_slave_address;
    next_irq_enable        = irq_enable;
    next_status            = status;
    next_rx_data           = rx_data;
    next_prdata            = 32'h0000_0000;
    if (apb_wr) begin
      unique case (paddr)
        ADDR_CONTROL: begin
          next_control = pwdata[15:0] & CONTROL_MASK;
          // Without stretch enable the release bit can only be set
          if (!control[BIT_STRETCH])
            next_control[BIT_RELEASE] = control[BIT_RELEASE] | pwdata[BIT_RELEASE];
        end
        ADDR_OWN_ADDR:   next_own_slave_address = pwdata[9:0];
        ADDR_IRQ_ENABLE: next_irq_enable = pwdata[ST_WIDTH-1:0];
        ADDR_IRQ_CLEAR:  next_status = status & ~pwdata[ST_WIDTH-1:0];
        default: ;
      endcase
    end
    next_control = next_control & ~{11'h000, done_mask};
    if (rel_hw_clr)
      next_control[BIT_RELEASE] = 1'b0;
    // Sticky events win over a clear in the same cycle
    if (seq_done)
      next_status[ST_SEQ_DONE] = 1'b1;
    if (sl_byte_done && sl_addr_ph && gcall_hit && control[BIT_GCALL])
      next_status[ST_GCALL] = 1'b1;
    if (sl_byte_done && sl_addr_ph && addr_match)
      next_status[ST_ADDR_HIT] = 1'b1;
    if (done_mask[BIT_RX_REQ]) begin
      next_status[ST_RX_BYTE] = 1'b1;
      next_rx_data = next_receive_shift_register;
    end
    if (apb_rd) begin
      unique case (paddr)
        ADDR_CONTROL:    next_prdata = {16'h0000, control};
        ADDR_OWN_ADDR:   next_prdata = {22'h000000, own_slave_address};
        ADDR_STATUS:     next_prdata = {28'h0000000, status};
        ADDR_IRQ_ENABLE: next_prdata = {28'h0000000, irq_enable};
        ADDR_RX_DATA:    next_prdata = {24'h000000, rx_data};
        ADDR_MISC:       next_prdata = {28'h0000000, seq};
        default:         next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control                <= CONTROL_RESET;
      own_slave_address      <= 10'h000;
      status                 <= '0;
      irq_enable             <= '0;
      rx_data                <= 8'h00;
      receive_shift_register <= 8'h00;
      bitcnt                 <= 3'd0;
      timer                  <= 16'h0000;
      seq                    <= SEQ_IDLE;
      drive                  <= '0;
      rx_phase               <= 1'b0;
      prdata                 <= 32'h0000_0000;
      sl_cnt                 <= 4'd0;
      sl_shift               <= 8'h00;
      sl_active              <= 1'b0;
      sl_addr_ph             <= 1'b0;
      sl_tx                  <= 1'b0;
      scl_d                  <= 1'b1;
      sda_d                  <= 1'b1;
      pready                 <= 1'b0;
      pins_owned             <= 1'b0;
      irq                    <= 1'b0;
      serial_clock_line_oe   <= 1'b0;
      serial_data_line_oe    <= 1'b0;
    end else begin
      control                <= next_control;
      own_slave_address      <= next_own_slave_address;
      status                 <= next_status;
      irq_enable             <= next_irq_enable;
      rx_data                <= next_rx_data;
      receive_shift_register <= next_receive_shift_register;
      bitcnt                 <= next_bitcnt;
      timer                  <= next_timer;
      seq                    <= next_seq;
      drive                  <= next_drive;
      rx_phase               <= next_rx_phase;
      prdata                 <= next_prdata;
      sl_cnt                 <= next_sl_cnt;
      sl_shift               <= next_sl_shift;
      sl_active              <= next_sl_active;
      sl_addr_ph             <= next_sl_addr_ph;
      sl_tx                  <= next_sl_tx;
      scl_d                  <= next_scl_d;
      sda_d                  <= next_sda_d;
      pready                 <= psel && !penable;  // No wait state, ready in first access cycle
      pins_owned             <= next_control[BIT_ENABLE];
      irq                    <= |(next_status & next_irq_enable);
      serial_clock_line_oe   <= next_control[BIT_ENABLE] && next_drive.scl_oe;
      serial_data_line_oe    <= next_control[BIT_ENABLE] && next_drive.sda_oe;
    end
  end

  // Open drain: the pad only ever pulls low
  assign serial_clock_line_out = 1'b0;
  assign serial_data_line_out  = 1'b0;
  assign pslverr               = 1'b0;

endmodule : ics_sequencer
`default_nettype wire

// ### common/ics_pkg.sv
// Package: register map, field positions and timing counts of the two-wire bus sequencer
package ics_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL    = 8'h00;
  localparam logic [7:0] ADDR_OWN_ADDR   = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] ADDR_TX_DATA    = 8'h14;
  localparam logic [7:0] ADDR_RX_DATA    = 8'h18;
  localparam logic [7:0] ADDR_MISC       = 8'h1c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE     = 15;
  localparam int BIT_IDLE_STOP  = 13;
  localparam int BIT_RELEASE    = 12;
  localparam int BIT_STRICT     = 11;
  localparam int BIT_LONG_ADDR  = 10;
  localparam int BIT_SLEW       = 9;
  localparam int BIT_LEVELS     = 8;
  localparam int BIT_GCALL      = 7;
  localparam int BIT_STRETCH    = 6;
  localparam int BIT_ACK_VALUE  = 5;
  localparam int BIT_ACK_REQ    = 4;
  localparam int BIT_RX_REQ     = 3;
  localparam int BIT_STOP_REQ   = 2;
  localparam int BIT_RSTART_REQ = 1;
  localparam int BIT_START_REQ  = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h1000;
  localparam logic [15:0] CONTROL_MASK  = 16'hbfff;

  // ----------------------------------------------------------------
  // Status / interrupt bits
  // ----------------------------------------------------------------
  localparam int ST_SEQ_DONE  = 0;
  localparam int ST_GCALL     = 1;
  localparam int ST_ADDR_HIT  = 2;
  localparam int ST_RX_BYTE   = 3;
  localparam int ST_WIDTH     = 4;

  // ----------------------------------------------------------------
  // Timing: half period of the generated serial clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 25;
  localparam int HALF_BIT_NS  = 5000;
  localparam int HALF_BIT_CYC = (HALF_BIT_NS * CLK_MHZ) / 1000;

  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'b0000,
    SEQ_ST_A   = 4'b0001,
    SEQ_ST_B   = 4'b0010,
    SEQ_RS_A   = 4'b0011,
    SEQ_RS_B   = 4'b0100,
    SEQ_SP_A   = 4'b0101,
    SEQ_SP_B   = 4'b0110,
    SEQ_BIT_LO = 4'b0111,
    SEQ_BIT_HI = 4'b1000,
    SEQ_SP_C   = 4'b1001
  } ics_seq_t;

  // Line drive toward the pads
  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } ics_pins_t;

endpackage : ics_pkg

// ### verilog/ics_sync.sv
// Module: two-flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module ics_sync #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // Two stages; the first is read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= {W{1'b1}};
      q    <= {W{1'b1}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : ics_sync
`default_nettype wire

// ### dv/ics_sequencer_assertions.sv
// Checker: port-level properties of the two-wire bus sequencer
`timescale 1ns/10ps
`default_nettype none
module ics_seq_chk
  import ics_pkg::*;
#(
  parameter int HALF_CYC = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        idle_mode,
  input wire logic        serial_clock_line_oe,
  input wire logic        serial_data_line_oe,
  input wire logic        pins_owned
);
  // Long enough for a sequence that idle mode held back for a while
  localparam int SEQ_WAIT = 16 * HALF_CYC + 32;
  logic acc;
  logic wr_c;
  logic en;
  logic idle_stop;
  assign acc  = psel && penable && pready;
  assign wr_c = acc && pwrite && paddr == ADDR_CONTROL;
  // Shadow of the control bits that hardware never clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en   <= 1'b0;
      idle_stop <= 1'b0;
    end else if (wr_c) begin
      en   <= pwdata[BIT_ENABLE];
      idle_stop <= pwdata[BIT_IDLE_STOP];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_first_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  ctl_zero_a: assert property (acc && !pwrite && paddr == ADDR_CONTROL |->
    prdata[31:16] == 16'h0000 && !prdata[14]) else $error("unused control bits set");
  unmapped_a: assert property (acc && !pwrite && paddr > ADDR_MISC |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  lines_free_a: assert property (!pins_owned && !$past(pins_owned) |->
    !serial_clock_line_oe && !serial_data_line_oe) else $error("line driven while off");
  owned_follow_a: assert property (wr_c ##1 (!wr_c)[*2] |-> ##1 pins_owned == en)
    else $error("ownership differs from enable");
  idle_halt_a: assert property ((idle_stop && en && idle_mode)[*3] |->
    $stable(serial_clock_line_oe) && $stable(serial_data_line_oe)) else $error("ran in idle");
  start_cond_a: assert property (wr_c && en && pwdata[BIT_START_REQ] |->
    ##[1:SEQ_WAIT] $rose(serial_data_line_oe) && !serial_clock_line_oe)
    else $error("no start condition");
  stop_cond_a: assert property (wr_c && en && pwdata[BIT_STOP_REQ] |->
    ##[1:SEQ_WAIT] $fell(serial_data_line_oe) && !serial_clock_line_oe)
    else $error("no stop condition");
endmodule : ics_seq_chk
bind ics_sequencer ics_seq_chk #(.HALF_CYC(HALF_CYC)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .idle_mode,
  .serial_clock_line_oe, .serial_data_line_oe, .pins_owned);
`default_nettype wire

// ### dv/ics_bus_model.sv
// Partner: other devices on the two-wire bus, with pull-ups
`timescale 1ns/10ps
`default_nettype none
module ics_bus_model (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic [7:0] tx;
  logic       tx_on;
  logic       m_scl;
  logic       m_sda;
  logic       last;
  logic       st_seen;
  logic       sp_seen;
  int         rises;
  initial begin
    {tx, tx_on, last, st_seen, sp_seen} = '0;
    {m_scl, m_sda} = 2'b11;
    rises = 0;
  end
  // Open drain: released lines float to the pull-up level
  assign scl = !scl_oe && m_scl;
  assign sda = !sda_oe && m_sda && !(tx_on && !tx[7]);
  // Monitor of clock edges and line conditions
  always @(posedge scl) begin
    rises++;
    last = sda;
  end
  always @(negedge scl) if (tx_on) tx = tx << 1;
  always @(negedge sda) if (scl) st_seen = 1'b1;
  always @(posedge sda) if (scl) sp_seen = 1'b1;
  // Start, one byte and the ninth clock at 320 ns; clock left low
  task automatic drive_byte(input logic [7:0] b);
    m_sda = 1'b0;
    #160;
    for (int i = 8; i >= 0; i--) begin
      m_scl = 1'b0;
      #80 m_sda = (i == 0) ? 1'b1 : b[i-1];
      #80 m_scl = 1'b1;
      wait (scl);
      #160;
    end
    m_scl = 1'b0;
  endtask : drive_byte
  // Stop; waits while a slave stretches the clock
  task automatic stop_bus;
    #80 m_sda = 1'b0;
    #80 m_scl = 1'b1;
    wait (scl);
    #160 m_sda = 1'b1;
    #160;
  endtask : stop_bus
endmodule : ics_bus_model
`default_nettype wire

// ### dv/ics_sequencer_tb_top.sv
// Testbench: registers, master sequences, idle stop, slave side, interrupt
`timescale 1ns/10ps
`default_nettype none
module ics_sequencer_tb_top;
  import ics_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, idle_mode, ackv, pready, pslverr;
  logic scl, sda, scl_oe, sda_oe, owned, irq;
  logic [7:0] paddr, b, a;
  logic [31:0] pwdata, prdata, rd;
  int failures, n_checks, seed;
  logic [31:0] wv[4] = '{32'hffff_7fe0, 32'h40, 32'h1000, 32'h0};
  logic [31:0] ev[4] = '{32'h3fe0, 32'h40, 32'h1000, 32'h1000};
  ics_sequencer #(.HALF_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .idle_mode, .serial_clock_line_in(scl),
    .serial_clock_line_out(), .serial_clock_line_oe(scl_oe), .serial_data_line_in(sda),
    .serial_data_line_out(), .serial_data_line_oe(sda_oe), .pins_owned(owned), .irq);
  ics_bus_model bus (.scl_oe, .sda_oe, .scl, .sda);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // One APB transfer; held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic seq(input int n, input logic [31:0] v);
    apb(1'b1, ADDR_CONTROL, 32'h8000 | v | (32'h1 << n));
    clr(n);
  endtask : seq
  // Poll until the request bit drops; only then may the next be set
  task automatic clr(input int n);
    int t;
    t = 0;
    do begin
      apb(1'b0, ADDR_CONTROL, 32'h0);
      t++;
    end while (rd[n] !== 1'b0 && t < 100);
    chk("request bit", 32'(rd[n]), 32'h0);
  endtask : clr
  task automatic wait_oe(input logic want);
    for (int t = 0; t < 120 && scl_oe !== want; t++) @(posedge pclk);
  endtask : wait_oe
  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial begin
    #(40 * 20000);
    failures++;
    end_of_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, idle_mode} = '0;
    {failures, n_checks, seed} = {32'h0, 32'h0, 32'h5bd0};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("control reset", rd, 32'(CONTROL_RESET));
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CONTROL, wv[i]);
      apb(1'b0, ADDR_CONTROL, 32'h0);
      chk("control readback", rd, ev[i]);
    end
    apb(1'b1, 8'h20, 32'hffff_ffff);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    // Master: start, receive, acknowledge, repeated start, stop
    for (int k = 0; k < 3; k++) begin
      {b, ackv} = {8'($random(seed)), 1'($random(seed))};
      bus.st_seen = 1'b0;
      seq(BIT_START_REQ, 32'h0);
      chk("start seen", 32'(bus.st_seen), 32'h1);
      {bus.tx, bus.tx_on, bus.rises} = {b, 1'b1, 32'h0};
      seq(BIT_RX_REQ, 32'h0);
      bus.tx_on = 1'b0;
      chk("rx clocks", bus.rises, 32'h8);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("rx byte", rd, 32'(b));
      seq(BIT_ACK_REQ, 32'(ackv) << BIT_ACK_VALUE);
      chk("ack bit", 32'(bus.last), 32'(ackv));
      bus.st_seen = 1'b0;
      seq(BIT_RSTART_REQ, 32'h0);
      chk("restart seen", 32'(bus.st_seen), 32'h1);
      bus.sp_seen = 1'b0;
      seq(BIT_STOP_REQ, 32'h0);
      chk("stop seen", 32'(bus.sp_seen), 32'h1);
    end
    $display("test master done");
    // Idle with idle-stop set holds a start request back
    apb(1'b1, ADDR_CONTROL, 32'ha000);
    idle_mode <= 1'b1;
    apb(1'b1, ADDR_CONTROL, 32'ha001);
    repeat (20) @(posedge pclk);
    apb(1'b0, ADDR_CONTROL, 32'h0);
    chk("held in idle", 32'(rd[BIT_START_REQ]), 32'h1);
    idle_mode <= 1'b0;
    clr(BIT_START_REQ);
    seq(BIT_STOP_REQ, 32'h0);
    $display("test idle done");
    // Slave: general call on and off, interrupt raise, mask and clear
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, ADDR_IRQ_CLEAR, 32'hf);
      apb(1'b1, ADDR_IRQ_ENABLE, 32'h2);
      apb(1'b1, ADDR_CONTROL, 32'h9800 | (32'(g) << BIT_GCALL));
      bus.drive_byte(8'h00);
      bus.stop_bus();
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("gcall flag", 32'(rd[ST_GCALL]), 32'(g));
      chk("reserved addr", 32'(rd[ST_ADDR_HIT]), 32'h0);
      chk("irq raised", 32'(irq), 32'(g));
      apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
      apb(1'b1, ADDR_IRQ_CLEAR, 32'hf);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("irq masked", 32'(irq), 32'h0);
      chk("gcall cleared", 32'(rd[ST_GCALL]), 32'h0);
    end
    // Slave addressed with release low stretches the clock
    a = 8'h08 + (8'($random(seed)) & 8'h3f);
    apb(1'b1, ADDR_OWN_ADDR, 32'(a));
    // Release can be cleared only once stretch enable is already on
    repeat (2) apb(1'b1, ADDR_CONTROL, 32'h8040);
    fork
      bus.drive_byte({a[6:0], 1'b0});
      begin
        wait_oe(1'b1);
        chk("stretch", 32'(scl_oe), 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("own hit", 32'(rd[ST_ADDR_HIT]), 32'h1);
        apb(1'b1, ADDR_CONTROL, 32'h9040);
      end
    join
    wait_oe(1'b0);
    chk("released", 32'(scl_oe), 32'h0);
    bus.stop_bus();
    $display("test slave done");
    end_of_test();
  end
endmodule : ics_sequencer_tb_top
`default_nettype wire
